// *** tas_analyzer_model.sv ***
`timescale 1ns/1ps
module tas_analyzer_model (
  // working clock
  input wire logic pclk,
  // control pins from the host
  input wire tas_pkg::tas_pins_s pins,
  // status back to the host
  output tas_pkg::tas_stat_s stat
);
  logic [2:0] seq_ram [64];
  logic [5:0] state_latch = 6'h00;
  logic [5:0] ram_addr;
  // far-side sources, idle so the latch low bits stay at zero
  logic local_timing_match_n = 1'b1;
  logic local_arm_match_n = 1'b1;
  logic external_trigger_in = 1'b0;
  logic peer_link_in = 1'b0;
  logic wave_trigger_in = 1'b0;
  logic delay_terminal_n = 1'b1;
  logic raw_trigger_n;
  logic raw_arm_n;
  logic [3:0] qualified_trigger_cnt = 4'h0;
  logic [3:0] arm_cnt = 4'h0;
  logic qualified_trigger;
  logic qualified_arm;
  // gate outputs wired together: any high gate blocks the event
  assign raw_trigger_n =
    (local_timing_match_n & ~pins.local_match_link_en_n)
    | ~pins.state_a_link_en_n | ~pins.state_b_link_en_n
    | (~external_trigger_in & ~pins.qualified_trigger_ext_link_en_n)
    | (~peer_link_in & ~pins.qualified_trigger_peer_link_en_n)
    | (~wave_trigger_in & ~pins.qualified_trigger_wave_link_en_n);
  assign raw_arm_n = local_arm_match_n
    | (~external_trigger_in & ~pins.arm_ext_link_en_n)
    | (~peer_link_in & ~pins.arm_peer_link_en_n)
    | (~wave_trigger_in & ~pins.arm_wave_link_en_n);
  // filters reload while the event is false and stop at zero
  always @(posedge pclk) begin
    if (raw_trigger_n) begin
      qualified_trigger_cnt <= pins.qualified_trigger_filter_preset;
    end else if (qualified_trigger_cnt != 4'h0) begin
      qualified_trigger_cnt <= qualified_trigger_cnt - 4'h1;
    end
    if (raw_arm_n) begin
      arm_cnt <= pins.arm_filter_preset;
    end else if (arm_cnt != 4'h0) begin
      arm_cnt <= arm_cnt - 4'h1;
    end
  end
  assign qualified_trigger = !raw_trigger_n && qualified_trigger_cnt == 4'h0;
  assign qualified_arm = !raw_arm_n && arm_cnt == 4'h0;
  // load gates wired-or with the latch
  assign ram_addr = pins.seq_load_select ?
    (pins.setup_word[8:3] | state_latch) : state_latch;
  always @(posedge pclk) begin
    if (!pins.seq_ram_write_n) begin
      seq_ram[ram_addr] <= pins.setup_word[2:0];
    end
  end
  // clock inhibited during setup; arm, trigger, delay idle
  always @(posedge pclk or negedge pins.seq_state_reset_n) begin
    if (!pins.seq_state_reset_n) begin
      state_latch <= 6'h00;
    end else if (!pins.seq_load_select) begin
      state_latch <= {seq_ram[ram_addr], ~delay_terminal_n,
        qualified_trigger, qualified_arm};
    end
  end
  assign stat.state_bits = state_latch[5:3];
  assign stat.triggered_flag = state_latch[5:3] == 3'h7;
endmodule : tas_analyzer_model

// *** tas_host_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - local match enable held active, both state-analyzer enables held off
// - external enable driven active only when the external link is chosen
// - peer-analyzer enable driven active only when a peer link is chosen and we are the link slave
// - waveform enable driven active when the waveform link is chosen
// - filter preset 0 to 9 loaded while counter is in load mode
// - ram of 64 three-bit words, data bits 0 to 2, write strobe
// - state latch reset to zero and ram loaded at setup
// - load select dropped for run, latch then steps from address 0
// - without link, master: triggered flag may drive outgoing link
// - with link, slave: incoming link feeds arm and trigger linkers
module tas_host_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analyzer control pins
  output tas_pkg::tas_pins_s pins,
  // analyzer status pins
  input wire tas_pkg::tas_stat_s stat_in
);

  localparam int CTRL_W_L = tas_pkg::CTRL_W;

  tas_pkg::tas_stat_s stat;
  logic [CTRL_W_L-1:0] ctrl;
  logic [CTRL_W_L-1:0] next_ctrl;
  logic [7:0] filt;
  logic [7:0] next_filt;
  logic [tas_pkg::SW_W-1:0] sword;
  logic [tas_pkg::SW_W-1:0] next_sword;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  tas_pkg::tas_seq_e seq;
  tas_pkg::tas_seq_e next_seq;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  tas_pkg::tas_pins_s next_pins;
  logic [7:0] off;
  logic access;
  logic commit;
  logic busy;
  logic go_write;
  logic go_reset;

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("tas_host_ctrl: ADDR_W must lie in 8..32");
    end
  end

  function automatic logic preset_ok(input logic [3:0] v);
    preset_ok = (v <= tas_pkg::FILT_MAX);
  endfunction : preset_ok

  // status pins are asynchronous to pclk
  tas_sync2 #(
    .W(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(stat_in),
    .q(stat)
  );

  assign off = paddr[7:0];
  assign access = psel & penable & ~pready;
  // writes take effect on the edge where the master sees pready
  assign commit = psel & penable & pready & pwrite & ~pslverr;
  assign busy = (seq != tas_pkg::TAS_IDLE);
  assign go_write = commit & (off == tas_pkg::OFF_SEQ_WORD);
  assign go_reset = commit & (off == tas_pkg::OFF_CMD) &
                    pwdata[tas_pkg::CMD_RESET_STATE];

  // apb decode and register file
  always_comb begin
    next_ctrl = ctrl;
    next_filt = filt;
    next_sword = sword;
    next_prdata = prdata;
    next_pready = access;
    next_pslverr = 1'b0;
    if (access) begin
      next_prdata = 32'h0000_0000;
      unique case (off)
        tas_pkg::OFF_CTRL: begin
          next_prdata[CTRL_W_L-1:0] = ctrl;
        end
        tas_pkg::OFF_FILTER: begin
          next_prdata[7:0] = filt;
          // presets above 9 cannot be served by the decade filter
          if (pwrite && (!preset_ok(pwdata[tas_pkg::FB_QUALIFIED_TRIGGER +: 4]) ||
              !preset_ok(pwdata[tas_pkg::FB_ARM +: 4]))) begin
            next_pslverr = 1'b1;
          end
        end
        tas_pkg::OFF_SEQ_WORD: begin
          next_prdata[tas_pkg::SW_W-1:0] = sword;
          // ram writes only make sense with the address steered by us
          if (pwrite && (busy || !ctrl[tas_pkg::CB_LOAD_SEL])) begin
            next_pslverr = 1'b1;
          end
        end
        tas_pkg::OFF_CMD: begin
          if (pwrite && busy) begin
            next_pslverr = 1'b1;
          end
        end
        tas_pkg::OFF_STATUS: begin
          next_prdata[tas_pkg::ST_STATE_LO +: 3] = stat.state_bits;
          next_prdata[tas_pkg::ST_TRIGGERED] = stat.triggered_flag;
          next_prdata[tas_pkg::ST_BUSY] = busy;
          next_pslverr = pwrite;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (commit && pstrb[0] && off == tas_pkg::OFF_FILTER) begin
      next_filt = pwdata[7:0];
    end
    if (commit && off == tas_pkg::OFF_CTRL) begin
      if (pstrb[0]) begin
        next_ctrl[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        // clearing load select hands the ram address to the latch
        next_ctrl[CTRL_W_L-1:8] = pwdata[CTRL_W_L-1:8];
      end
    end
    if (go_write) begin
      next_sword = pwdata[tas_pkg::SW_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tas_pkg::CTRL_RST;
      filt <= tas_pkg::FILT_RST;
      sword <= tas_pkg::SW_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      filt <= next_filt;
      sword <= next_sword;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // strobe sequencer: ram write and state latch reset
  always_comb begin
    next_seq = seq;
    next_cnt = cnt;
    unique case (seq)
      tas_pkg::TAS_IDLE: begin
        if (go_write) begin
          next_seq = tas_pkg::TAS_WSET;
        end else if (go_reset) begin
          next_seq = tas_pkg::TAS_RST;
          next_cnt = tas_pkg::RST_PULSE_CNT;
        end
      end
      tas_pkg::TAS_WSET: begin
        // address and data settle one cycle before the strobe
        next_seq = tas_pkg::TAS_WSTB;
        next_cnt = tas_pkg::WR_PULSE_CNT;
      end
      tas_pkg::TAS_WSTB: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_seq = tas_pkg::TAS_WHLD;
        end
      end
      tas_pkg::TAS_WHLD: begin
        next_seq = tas_pkg::TAS_IDLE;
      end
      tas_pkg::TAS_RST: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_seq = tas_pkg::TAS_IDLE;
        end
      end
      default: begin
        next_seq = tas_pkg::TAS_IDLE;
        next_cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= tas_pkg::TAS_IDLE;
      cnt <= 4'h0;
    end else begin
      seq <= next_seq;
      cnt <= next_cnt;
    end
  end

  // pin levels, all registered
  always_comb begin
    next_pins = tas_pkg::PINS_RST;
    next_pins.local_match_link_en_n = 1'b0;
    next_pins.state_a_link_en_n = 1'b1;
    next_pins.state_b_link_en_n = 1'b1;
    next_pins.qualified_trigger_ext_link_en_n = ~ctrl[tas_pkg::CB_QUALIFIED_TRIGGER_EXT];
    next_pins.arm_ext_link_en_n = ~ctrl[tas_pkg::CB_ARM_EXT];
    // peer input exists only when we are a slave of the link
    next_pins.qualified_trigger_peer_link_en_n =
      ~(ctrl[tas_pkg::CB_QUALIFIED_TRIGGER_PEER] & ctrl[tas_pkg::CB_LINK_CFG]);
    next_pins.arm_peer_link_en_n =
      ~(ctrl[tas_pkg::CB_ARM_PEER] & ctrl[tas_pkg::CB_LINK_CFG]);
    next_pins.qualified_trigger_wave_link_en_n = ~ctrl[tas_pkg::CB_QUALIFIED_TRIGGER_WAVE];
    next_pins.arm_wave_link_en_n = ~ctrl[tas_pkg::CB_ARM_WAVE];
    next_pins.qualified_trigger_filter_preset = filt[tas_pkg::FB_QUALIFIED_TRIGGER +: 4];
    next_pins.arm_filter_preset = filt[tas_pkg::FB_ARM +: 4];
    next_pins.seq_load_select = ctrl[tas_pkg::CB_LOAD_SEL];
    next_pins.setup_word = sword;
    next_pins.seq_ram_write_n = (seq != tas_pkg::TAS_WSTB);
    next_pins.seq_state_reset_n = (seq != tas_pkg::TAS_RST);
    next_pins.delay_clock_select = ctrl[tas_pkg::CB_DLY_SEL];
    // master and slave roles exclude each other
    next_pins.link_master_en =
      ~ctrl[tas_pkg::CB_LINK_CFG] & ctrl[tas_pkg::CB_LINK_OUT];
    next_pins.link_slave_en = ctrl[tas_pkg::CB_LINK_CFG];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= tas_pkg::PINS_RST;
    end else begin
      pins <= next_pins;
    end
  end

endmodule : tas_host_ctrl

// *** tas_host_ctrl_bench.sv ***
`timescale 1ns/1ps
module tas_host_ctrl_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  tas_pkg::tas_pins_s pins;
  tas_pkg::tas_stat_s stat;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  initial begin
    forever #2 pclk = ~pclk;
  end
  tas_host_ctrl #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .stat_in(stat));
  tas_analyzer_model u_dev (.pclk(pclk), .pins(pins), .stat(stat));
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check_word
  task check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_bit
  // holds the request until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    check_bit(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, err);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    check_word(rd, exp);
  endtask : rd_chk
  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, tas_pkg::OFF_STATUS, 32'h0, 1'b0);
      n++;
    end while (rd[tas_pkg::ST_BUSY] !== 1'b0 && n < 40);
    check_bit(rd[tas_pkg::ST_BUSY], 1'b0);
  endtask : wait_idle
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_bit(pins.local_match_link_en_n, 1'b0);
    check_bit(pins.state_a_link_en_n & pins.state_b_link_en_n, 1'b1);
    rd_chk(tas_pkg::OFF_CTRL, 32'h200);
    rd_chk(tas_pkg::OFF_FILTER, 32'h0);
    // each link enable alone, slave so peer may drive
    for (int i = 0; i < 6; i++) begin
      wr(tas_pkg::OFF_CTRL, 32'h240 | (32'h1 << i), 1'b0);
      repeat (3) @(posedge pclk);
      check_word(32'({pins.qualified_trigger_ext_link_en_n, pins.qualified_trigger_peer_link_en_n,
        pins.qualified_trigger_wave_link_en_n, pins.arm_ext_link_en_n,
        pins.arm_peer_link_en_n, pins.arm_wave_link_en_n}),
        {26'h0, ~(6'h20 >> i)});
      check_bit(pins.link_slave_en, 1'b1);
    end
    wr(tas_pkg::OFF_CTRL, 32'h382, 1'b0);
    repeat (3) @(posedge pclk);
    check_bit(pins.qualified_trigger_peer_link_en_n, 1'b1);
    check_bit(pins.link_master_en, 1'b1);
    check_bit(pins.delay_clock_select, 1'b1);
    wr(tas_pkg::OFF_FILTER, 32'h99, 1'b0);
    wr(tas_pkg::OFF_FILTER, 32'ha0, 1'b1);
    wr(tas_pkg::OFF_FILTER, 32'h0a, 1'b1);
    rd_chk(tas_pkg::OFF_FILTER, 32'h99);
    check_word(32'({pins.arm_filter_preset, pins.qualified_trigger_filter_preset}),
      32'h99);
    wr(8'h14, 32'h1, 1'b1);
    wr(tas_pkg::OFF_STATUS, 32'h1, 1'b1);
    wr(tas_pkg::OFF_CTRL, 32'h200, 1'b0);
    wr(tas_pkg::OFF_SEQ_WORD, 32'h007, 1'b0);
    wr(tas_pkg::OFF_SEQ_WORD, 32'h1c7, 1'b1);
    wait_idle();
    wr(tas_pkg::OFF_SEQ_WORD, 32'h1c7, 1'b0);
    wait_idle();
    wr(tas_pkg::OFF_CMD, 32'h1, 1'b0);
    wait_idle();
    repeat (4) @(posedge pclk);
    rd_chk(tas_pkg::OFF_STATUS, 32'h00);
    wr(tas_pkg::OFF_CTRL, 32'h000, 1'b0);
    wr(tas_pkg::OFF_SEQ_WORD, 32'h007, 1'b1);
    repeat (8) @(posedge pclk);
    rd_chk(tas_pkg::OFF_STATUS, 32'h0f);
    // reset again in mid-run: setup levels must come back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_bit(pins.seq_load_select, 1'b1);
    rd_chk(tas_pkg::OFF_CTRL, 32'h200);
    rd_chk(tas_pkg::OFF_FILTER, 32'h0);
    summarize();
  end
endmodule : tas_host_ctrl_bench
bind tas_host_ctrl tas_host_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .stat_in(stat_in));

// *** tas_host_ctrl_sva.sv ***
`timescale 1ns/1ps
module tas_host_ctrl_sva #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // analyzer side
  input wire tas_pkg::tas_pins_s pins,
  input wire tas_pkg::tas_stat_s stat_in
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_local_held: assert property (
    !pins.local_match_link_en_n && pins.state_a_link_en_n
    && pins.state_b_link_en_n) else $error("local enables moved");
  chk_peer_slave: assert property (
    (!pins.qualified_trigger_peer_link_en_n || !pins.arm_peer_link_en_n)
    |-> pins.link_slave_en) else $error("peer enable without link");
  chk_link_excl: assert property (
    !(pins.link_master_en && pins.link_slave_en))
    else $error("master and slave together");
  chk_qualified_trigger_preset: assert property (
    pins.qualified_trigger_filter_preset <= 4'h9) else $error("trigger preset above 9");
  chk_arm_preset: assert property (
    pins.arm_filter_preset <= 4'h9) else $error("arm preset above 9");
  chk_ram_pulse: assert property (
    $fell(pins.seq_ram_write_n) |-> !pins.seq_ram_write_n [*3]
    ##1 pins.seq_ram_write_n) else $error("ram strobe width");
  chk_word_hold: assert property (
    !pins.seq_ram_write_n |-> $stable(pins.setup_word)
    && pins.seq_load_select) else $error("word moved under strobe");
  chk_latch_reset: assert property (
    $fell(pins.seq_state_reset_n) |-> !pins.seq_state_reset_n [*3]
    ##1 pins.seq_state_reset_n) else $error("latch reset width");
  chk_one_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
endmodule : tas_host_ctrl_sva

// *** tas_pkg.sv ***
package tas_pkg;

  // own register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FILTER = 8'h04;
  localparam logic [7:0] OFF_SEQ_WORD = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_W = 10;
  localparam int CB_QUALIFIED_TRIGGER_EXT = 0;
  localparam int CB_QUALIFIED_TRIGGER_PEER = 1;
  localparam int CB_QUALIFIED_TRIGGER_WAVE = 2;
  localparam int CB_ARM_EXT = 3;
  localparam int CB_ARM_PEER = 4;
  localparam int CB_ARM_WAVE = 5;
  localparam int CB_LINK_CFG = 6;
  localparam int CB_LINK_OUT = 7;
  localparam int CB_DLY_SEL = 8;
  localparam int CB_LOAD_SEL = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h200;

  // filter register fields
  localparam int FB_QUALIFIED_TRIGGER = 0;
  localparam int FB_ARM = 4;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [3:0] FILT_MAX = 4'h9;

  // setup word: ram address in 8:3, ram data in 2:0
  localparam int SW_W = 9;
  localparam int SW_ADDR_LO = 3;
  localparam logic [SW_W-1:0] SW_RST = 9'h000;

  // command and status fields
  localparam int CMD_RESET_STATE = 0;
  localparam int ST_STATE_LO = 0;
  localparam int ST_TRIGGERED = 3;
  localparam int ST_BUSY = 4;

  // strobe timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WR_PULSE_NS = 12;
  localparam int RST_PULSE_NS = 12;
  localparam int WR_PULSE_CYC =
    (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] WR_PULSE_CNT = 4'(WR_PULSE_CYC);
  localparam logic [3:0] RST_PULSE_CNT = 4'(RST_PULSE_CYC);

  typedef enum logic [4:0] {
    TAS_IDLE = 5'b00001,
    TAS_WSET = 5'b00010,
    TAS_WSTB = 5'b00100,
    TAS_WHLD = 5'b01000,
    TAS_RST = 5'b10000
  } tas_seq_e;

  // levels driven onto the analyzer's control pins
  typedef struct packed {
    logic local_match_link_en_n;
    logic state_a_link_en_n;
    logic state_b_link_en_n;
    logic qualified_trigger_ext_link_en_n;
    logic qualified_trigger_peer_link_en_n;
    logic qualified_trigger_wave_link_en_n;
    logic arm_ext_link_en_n;
    logic arm_peer_link_en_n;
    logic arm_wave_link_en_n;
    logic [3:0] qualified_trigger_filter_preset;
    logic [3:0] arm_filter_preset;
    logic seq_load_select;
    logic [SW_W-1:0] setup_word;
    logic seq_ram_write_n;
    logic seq_state_reset_n;
    logic delay_clock_select;
    logic link_master_en;
    logic link_slave_en;
  } tas_pins_s;

  localparam tas_pins_s PINS_RST = '{
    local_match_link_en_n: 1'b0,
    state_a_link_en_n: 1'b1,
    state_b_link_en_n: 1'b1,
    qualified_trigger_ext_link_en_n: 1'b1,
    qualified_trigger_peer_link_en_n: 1'b1,
    qualified_trigger_wave_link_en_n: 1'b1,
    arm_ext_link_en_n: 1'b1,
    arm_peer_link_en_n: 1'b1,
    arm_wave_link_en_n: 1'b1,
    qualified_trigger_filter_preset: 4'h0,
    arm_filter_preset: 4'h0,
    seq_load_select: 1'b1,
    setup_word: 9'h000,
    seq_ram_write_n: 1'b1,
    seq_state_reset_n: 1'b1,
    delay_clock_select: 1'b0,
    link_master_en: 1'b0,
    link_slave_en: 1'b0
  };

  // status lines coming back from the analyzer
  typedef struct packed {
    logic [2:0] state_bits;
    logic triggered_flag;
  } tas_stat_s;

endpackage : tas_pkg

// *** tas_sync2.sv ***
`timescale 1ns/1ps
module tas_sync2 #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous input and its synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  initial begin
    if (W < 1) begin
      $error("tas_sync2: W must be at least 1");
    end
  end

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule : tas_sync2
